// >>> flash_ctl_defines.vh
// constants shared by the flash status controller files
// Notes on behaviour
// - command cycles are writes; array reads and identification fourth cycle are reads.
// - controller issues reset command after timing-limit failure; software issues it after identification.
// - bypass entry precedes any two-cycle program; flash rejects it otherwise.
// - controller issues bypass exit command to leave bypass mode.
// - controller polls at program address or inside a selected erase sector.
// - after polled bit shows true data, valid byte comes from next read.
`ifndef FLASH_CTL_DEFINES_VH
`define FLASH_CTL_DEFINES_VH
// ==========================================
// controller register offsets
`define REG_CMD 4'h0
`define REG_ADDR 4'h1
`define REG_DATA 4'h2
`define REG_STATUS 4'h3
`define REG_RDATA 4'h4
// ==========================================
// operation codes written to the command register
`define OP_READ 4'h0
`define OP_PROGRAM 4'h1
`define OP_SECTOR_ERASE 4'h2
`define OP_CHIP_ERASE 4'h3
`define OP_RESET 4'h4
`define OP_SUSPEND 4'h5
`define OP_RESUME 4'h6
`define OP_AUTOSEL 4'h7
`define OP_BYPASS_ENTER 4'h8
`define OP_BYPASS_PROG 4'h9
`define OP_BYPASS_EXIT 4'ha
`define OP_RAW_WRITE 4'hb
// ==========================================
// flash command cycle values
`define UNLOCK_ADDR1 19'h00555
`define UNLOCK_ADDR2 19'h002aa
`define UNLOCK_DATA1 8'haa
`define UNLOCK_DATA2 8'h55
`define CMD_PROGRAM 8'ha0
`define CMD_ERASE_SETUP 8'h80
`define CMD_CHIP_ERASE 8'h10
`define CMD_SECTOR_ERASE 8'h30
`define CMD_RESET 8'hf0
`define CMD_SUSPEND 8'hb0
`define CMD_RESUME 8'h30
`define CMD_AUTOSEL 8'h90
`define CMD_BYPASS 8'h20
`define CMD_BYPASS_EXIT1 8'h90
`define CMD_BYPASS_EXIT2 8'h00
// ==========================================
// status bit positions on the data bus
`define BIT_POLL 7
`define BIT_TOGGLE1 6
`define BIT_LIMIT 5
`define BIT_ETIMER 3
`define BIT_TOGGLE2 2
// ==========================================
// bus cycle timing
`define T_STROBE_NS 50
`define T_ACCESS_NS 100
`define CLK_PERIOD_NS 25
`endif

// >>> flash_bus_cycle.v
// one bus cycle engine for the parallel flash pins
`timescale 1ns/100ps
`include "flash_ctl_defines.vh"
module flash_bus_cycle #(
    parameter STROBE_CYC = (`T_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter ACCESS_CYC = (`T_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // request side
    input wire start_i,
    input wire write_i,
    input wire [18:0] addr_i,
    input wire [7:0] wdata_i,
    output wire busy_o,
    output reg done_o,
    output reg [7:0] rdata_o,
    // flash pins
    output reg [18:0] fl_addr_o,
    output reg fl_ce_n_o,
    output reg fl_oe_n_o,
    output reg fl_we_n_o,
    output reg [7:0] fl_dq_o,
    output reg fl_dq_oe_o,
    input wire [7:0] fl_dq_i
);
    localparam S_IDLE = 2'd0;
    localparam S_SETUP = 2'd1;
    localparam S_PULSE = 2'd2;
    localparam S_HOLD = 2'd3;
    reg [1:0] state;
    reg [7:0] cnt;
    reg is_write;
    assign busy_o = (state != S_IDLE);
    // ==========================================
    // cycle sequencer: address set up a cycle before strobes so the flash
    // latches address on the strobe fall and data on its rise
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= S_IDLE;
            cnt <= 8'h00;
            is_write <= 1'b0;
            done_o <= 1'b0;
            rdata_o <= 8'h00;
            fl_addr_o <= 19'h00000;
            fl_ce_n_o <= 1'b1;
            fl_oe_n_o <= 1'b1;
            fl_we_n_o <= 1'b1;
            fl_dq_o <= 8'h00;
            fl_dq_oe_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (start_i) begin
                        fl_addr_o <= addr_i;
                        fl_dq_o <= wdata_i;
                        fl_dq_oe_o <= write_i;
                        is_write <= write_i;
                        fl_ce_n_o <= 1'b0;
                        state <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    fl_we_n_o <= ~is_write;
                    fl_oe_n_o <= is_write;
                    cnt <= is_write ? STROBE_CYC[7:0] : ACCESS_CYC[7:0];
                    state <= S_PULSE;
                end
                S_PULSE: begin
                    if (cnt <= 8'h01) begin
                        // write strobe rises first, data held past it
                        fl_we_n_o <= 1'b1;
                        fl_oe_n_o <= 1'b1;
                        rdata_o <= fl_dq_i;
                        state <= S_HOLD;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                default: begin
                    fl_ce_n_o <= 1'b1;
                    fl_dq_oe_o <= 1'b0;
                    done_o <= 1'b1;
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule // flash_bus_cycle

// >>> flash_status_ctl.v
// controller that sequences flash commands and polls write status
`timescale 1ns/100ps
`include "flash_ctl_defines.vh"
module flash_status_ctl #(
    parameter MAX_POLLS = 16'hffff
) (
    // clock and reset
    input wire CLOCK_I,
    input wire RST_N_I,
    // software port
    input wire [3:0] ADDR_I,
    input wire [31:0] WDATA_I,
    input wire WR_I,
    input wire RD_I,
    output reg [31:0] RDATA_O,
    // flash pins
    output wire [18:0] FL_ADDR_O,
    output wire FL_CE_N_O,
    output wire FL_OE_N_O,
    output wire FL_WE_N_O,
    output wire [7:0] FL_DQ_O,
    output wire FL_DQ_OE_O,
    input wire [7:0] FL_DQ_I,
    input wire FL_READY_BUSY_N_I
);
    localparam S_IDLE = 3'd0;
    localparam S_SEQ = 3'd1;
    localparam S_POLL = 3'd2;
    localparam S_CONFIRM = 3'd3;
    localparam S_FINAL = 3'd4;
    localparam S_WAITRB = 3'd5;
    // ==========================================
    // software registers
    reg [3:0] op;
    reg [18:0] op_addr;
    reg [7:0] op_data;
    reg [7:0] result;
    reg busy;
    reg fail;
    reg bypass;
    reg suspended;
    reg [2:0] state;
    reg [2:0] step;
    reg [15:0] polls;
    reg [7:0] prev;
    // ready/busy pin synchroniser, three stages
    reg rb_s1, rb_s2, rb_s3, rb_level;
    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rb_s1 <= 1'b1;
            rb_s2 <= 1'b1;
            rb_s3 <= 1'b1;
            rb_level <= 1'b1;
        end else begin
            rb_s1 <= FL_READY_BUSY_N_I;
            rb_s2 <= rb_s1;
            rb_s3 <= rb_s2;
            if (rb_s2 == rb_s3)
                rb_level <= rb_s3;
        end
    end
    // ==========================================
    // bus cycle engine
    reg cyc_start, cyc_write;
    reg [18:0] cyc_addr;
    reg [7:0] cyc_wdata;
    wire cyc_busy, cyc_done;
    wire [7:0] cyc_rdata;
    flash_bus_cycle u_cycle (
        .clk_i(CLOCK_I),
        .rst_n_i(RST_N_I),
        .start_i(cyc_start),
        .write_i(cyc_write),
        .addr_i(cyc_addr),
        .wdata_i(cyc_wdata),
        .busy_o(cyc_busy),
        .done_o(cyc_done),
        .rdata_o(cyc_rdata),
        .fl_addr_o(FL_ADDR_O),
        .fl_ce_n_o(FL_CE_N_O),
        .fl_oe_n_o(FL_OE_N_O),
        .fl_we_n_o(FL_WE_N_O),
        .fl_dq_o(FL_DQ_O),
        .fl_dq_oe_o(FL_DQ_OE_O),
        .fl_dq_i(FL_DQ_I)
    );
    // ==========================================
    // command cycle table: returns {last, write, addr, data} for each step
    reg [28:0] seq;
    wire is_erase = (op == `OP_SECTOR_ERASE) || (op == `OP_CHIP_ERASE);
    wire [18:0] sector_addr = {op_addr[18:13], 13'h0000};
    always @* begin
        seq = {1'b1, 1'b0, op_addr, 8'h00};
        case (op)
            `OP_PROGRAM, `OP_SECTOR_ERASE, `OP_CHIP_ERASE, `OP_AUTOSEL, `OP_BYPASS_ENTER: begin
                // unlock cycles use only the low address bits
                // second unlock pair only for erase, else program data lands as a cmd
                if (step == 3'd0 || (step == 3'd3 && is_erase))
                    seq = {1'b0, 1'b1, `UNLOCK_ADDR1, `UNLOCK_DATA1};
                else if (step == 3'd1 || (step == 3'd4 && is_erase))
                    seq = {1'b0, 1'b1, `UNLOCK_ADDR2, `UNLOCK_DATA2};
                else if (step == 3'd2 && op == `OP_PROGRAM)
                    seq = {1'b0, 1'b1, `UNLOCK_ADDR1, `CMD_PROGRAM};
                else if (step == 3'd2 && op == `OP_AUTOSEL)
                    seq = {1'b0, 1'b1, `UNLOCK_ADDR1, `CMD_AUTOSEL};
                else if (step == 3'd2 && op == `OP_BYPASS_ENTER)
                    seq = {1'b1, 1'b1, `UNLOCK_ADDR1, `CMD_BYPASS};
                else if (step == 3'd2)
                    seq = {1'b0, 1'b1, `UNLOCK_ADDR1, `CMD_ERASE_SETUP};
                else if (op == `OP_PROGRAM)
                    seq = {1'b1, 1'b1, op_addr, op_data};
                else if (op == `OP_AUTOSEL)
                    seq = {1'b1, 1'b0, op_addr, 8'h00};
                else if (op == `OP_CHIP_ERASE)
                    seq = {1'b1, 1'b1, `UNLOCK_ADDR1, `CMD_CHIP_ERASE};
                else
                    seq = {1'b1, 1'b1, sector_addr, `CMD_SECTOR_ERASE};
            end
            `OP_BYPASS_PROG: begin
                if (step == 3'd0)
                    seq = {1'b0, 1'b1, 19'h00000, `CMD_PROGRAM};
                else
                    seq = {1'b1, 1'b1, op_addr, op_data};
            end
            `OP_BYPASS_EXIT: begin
                if (step == 3'd0)
                    seq = {1'b0, 1'b1, 19'h00000, `CMD_BYPASS_EXIT1};
                else
                    seq = {1'b1, 1'b1, 19'h00000, `CMD_BYPASS_EXIT2};
            end
            `OP_RESET: seq = {1'b1, 1'b1, 19'h00000, `CMD_RESET};
            `OP_SUSPEND: seq = {1'b1, 1'b1, 19'h00000, `CMD_SUSPEND};
            `OP_RESUME: seq = {1'b1, 1'b1, 19'h00000, `CMD_RESUME};
            `OP_RAW_WRITE: seq = {1'b1, 1'b1, op_addr, op_data};
            default: seq = {1'b1, 1'b0, op_addr, 8'h00};
        endcase
    end
    wire polls_op = (op == `OP_PROGRAM) || (op == `OP_BYPASS_PROG) ||
        (op == `OP_SECTOR_ERASE) || (op == `OP_CHIP_ERASE);
    // polls read at program address or inside erase sector
    wire [18:0] poll_addr = is_erase ? sector_addr : op_addr;
    // bypass program refused unless bypass was entered
    wire op_ok = (op != `OP_BYPASS_PROG || bypass) && (op != `OP_RESUME || suspended);
    // ==========================================
    // operation sequencer
    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            op <= `OP_READ;
            op_addr <= 19'h00000;
            op_data <= 8'h00;
            result <= 8'h00;
            busy <= 1'b0;
            fail <= 1'b0;
            bypass <= 1'b0;
            suspended <= 1'b0;
            state <= S_IDLE;
            step <= 3'd0;
            polls <= 16'h0000;
            prev <= 8'h00;
            cyc_start <= 1'b0;
            cyc_write <= 1'b0;
            cyc_addr <= 19'h00000;
            cyc_wdata <= 8'h00;
        end else begin
            cyc_start <= 1'b0;
            if (WR_I && ADDR_I == `REG_ADDR && !busy)
                op_addr <= WDATA_I[18:0];
            else if (WR_I && ADDR_I == `REG_DATA && !busy)
                op_data <= WDATA_I[7:0];
            else if (WR_I && ADDR_I == `REG_CMD && !busy) begin
                op <= WDATA_I[3:0];
                busy <= 1'b1;
                fail <= 1'b0;
                step <= 3'd0;
                state <= S_SEQ;
            end
            case (state)
                S_SEQ: begin
                    if (!op_ok) begin
                        fail <= 1'b1;
                        busy <= 1'b0;
                        state <= S_IDLE;
                    end else if (!cyc_busy && !cyc_start) begin
                        cyc_start <= 1'b1;
                        cyc_write <= seq[27];
                        cyc_addr <= seq[26:8];
                        cyc_wdata <= seq[7:0];
                        state <= S_FINAL;
                    end
                end
                S_FINAL: begin
                    if (cyc_done) begin
                        if (!seq[28]) begin
                            step <= step + 3'd1;
                            state <= S_SEQ;
                        end else begin
                            result <= cyc_rdata;
                            if (op == `OP_BYPASS_ENTER)
                                bypass <= 1'b1;
                            if (op == `OP_BYPASS_EXIT || op == `OP_RESET)
                                bypass <= 1'b0;
                            if (op == `OP_SUSPEND)
                                suspended <= 1'b1;
                            if (op == `OP_RESUME || op == `OP_RESET)
                                suspended <= 1'b0;
                            polls <= 16'h0000;
                            // status valid from the last strobe rise on
                            state <= polls_op ? S_POLL : S_IDLE;
                            busy <= polls_op;
                        end
                    end
                end
                S_POLL: begin
                    if (!cyc_busy && !cyc_start) begin
                        cyc_start <= 1'b1;
                        cyc_write <= 1'b0;
                        cyc_addr <= poll_addr;
                        state <= S_CONFIRM;
                    end
                end
                S_CONFIRM: begin
                    if (cyc_done) begin
                        prev <= cyc_rdata;
                        polls <= polls + 16'h0001;
                        // erase done shows 1; program done shows true bit 7
                        if (cyc_rdata[`BIT_POLL] == (is_erase | op_data[`BIT_POLL])) begin
                            state <= S_WAITRB;
                        end else if (polls != 16'h0000 && cyc_rdata[`BIT_LIMIT] &&
                            (cyc_rdata[`BIT_TOGGLE1] != prev[`BIT_TOGGLE1])) begin
                            fail <= 1'b1;
                            op <= `OP_RESET;
                            step <= 3'd0;
                            state <= S_SEQ;
                        end else if (polls == MAX_POLLS) begin
                            fail <= 1'b1;
                            busy <= 1'b0;
                            state <= S_IDLE;
                        end else begin
                            state <= S_POLL;
                        end
                    end
                end
                S_WAITRB: begin
                    // extra read after bit 7 settles, since other bits lag
                    if (!cyc_busy && !cyc_start && rb_level) begin
                        cyc_start <= 1'b1;
                        cyc_write <= 1'b0;
                        cyc_addr <= poll_addr;
                        op <= `OP_READ;
                        step <= 3'd0;
                        state <= S_FINAL;
                    end
                end
                default: ;
            endcase
        end
    end
    // ==========================================
    // read port, data one cycle after strobe
    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I)
            RDATA_O <= 32'h00000000;
        else if (RD_I && ADDR_I == `REG_CMD)
            RDATA_O <= {28'h0000000, op};
        else if (RD_I && ADDR_I == `REG_ADDR)
            RDATA_O <= {13'h0000, op_addr};
        else if (RD_I && ADDR_I == `REG_DATA)
            RDATA_O <= {24'h000000, op_data};
        else if (RD_I && ADDR_I == `REG_STATUS)
            RDATA_O <= {26'h0000000, ~rb_level, suspended, bypass, fail, 1'b0, busy};
        else if (RD_I && ADDR_I == `REG_RDATA)
            RDATA_O <= {16'h0000, prev, result};
        else
            RDATA_O <= 32'h00000000;
    end
endmodule // flash_status_ctl

// >>> flash_status_monitor.sv
// assertion checker for the flash status controller pins
`timescale 1ns/100ps
module flash_status_monitor #(
    parameter MAX_POLLS = 16'hffff
) (
    // clock and reset
    input wire CLOCK_I,
    input wire RST_N_I,
    // software port
    input wire [3:0] ADDR_I,
    input wire [31:0] WDATA_I,
    input wire WR_I,
    input wire RD_I,
    input wire [31:0] RDATA_O,
    // flash pins
    input wire [18:0] FL_ADDR_O,
    input wire FL_CE_N_O,
    input wire FL_OE_N_O,
    input wire FL_WE_N_O,
    input wire [7:0] FL_DQ_O,
    input wire FL_DQ_OE_O,
    input wire [7:0] FL_DQ_I,
    input wire FL_READY_BUSY_N_I
);
    // ==========================================
    // strobe shapes, bus ownership and idle read data
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);
    sequence we_pulse;
        !FL_WE_N_O [*2] ##1 FL_WE_N_O;
    endsequence
    sequence oe_pulse;
        !FL_OE_N_O [*4] ##[1:2] FL_OE_N_O;
    endsequence
    a_we_width: assert property ($fell(FL_WE_N_O) |-> we_pulse)
        else $error("write strobe width wrong");
    a_oe_width: assert property ($fell(FL_OE_N_O) |-> oe_pulse)
        else $error("read strobe width wrong");
    a_ce_leads_we: assert property ($fell(FL_WE_N_O) |-> $past(!FL_CE_N_O))
        else $error("chip select not ahead of write strobe");
    a_write_hold: assert property (!FL_WE_N_O |-> $stable(FL_ADDR_O) && $stable(FL_DQ_O))
        else $error("address or data moved under write strobe");
    a_write_drives: assert property (!FL_WE_N_O |-> FL_DQ_OE_O && !FL_CE_N_O)
        else $error("write without data drive");
    a_read_quiet: assert property (!FL_OE_N_O |-> !FL_DQ_OE_O && FL_WE_N_O && !FL_CE_N_O)
        else $error("read overlaps a drive");
    a_ce_idle: assert property (FL_CE_N_O |-> FL_WE_N_O && FL_OE_N_O)
        else $error("strobe outside chip select");
    a_rdata_zero: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
        else $error("read data outside its cycle");
endmodule // flash_status_monitor

bind flash_status_ctl flash_status_monitor #(.MAX_POLLS(MAX_POLLS)) flash_status_monitor_i (
    .CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .FL_ADDR_O(FL_ADDR_O),
    .FL_CE_N_O(FL_CE_N_O), .FL_OE_N_O(FL_OE_N_O), .FL_WE_N_O(FL_WE_N_O),
    .FL_DQ_O(FL_DQ_O), .FL_DQ_OE_O(FL_DQ_OE_O), .FL_DQ_I(FL_DQ_I),
    .FL_READY_BUSY_N_I(FL_READY_BUSY_N_I)
);

// >>> flash_partner.sv
// behavioural flash device facing the controller
`timescale 1ns/100ps
`include "flash_ctl_defines.vh"
module flash_partner #(
    parameter BUSY_NS = 1500,
    parameter [5:0] PROT_SEC = 6'h3f,
    parameter [7:0] ID_MFR = 8'h5c // arbitrary value
) (
    // flash pins
    input wire [18:0] addr_i,
    input wire ce_n_i,
    input wire oe_n_i,
    input wire we_n_i,
    input wire [7:0] dq_i,
    output wire [7:0] dq_o,
    output wire rb_n_o
);
    reg [7:0] mem [int];
    reg [7:0] q = 8'h00, last_wd = 8'h00, pv = 8'h00;
    reg [18:0] la = 19'h0, pa = 19'h0;
    reg [2:0] st = 3'h0;
    reg [5:0] es = 6'h0;
    reg busy = 0, lim = 0, ers = 0, all = 0, t1 = 0, t2 = 0, asel = 0, byp = 0, ok;
    int wcnt = 0, tok = 0;
    // open drain: released pin floats to the pull-up
    assign rb_n_o = busy ? 1'b0 : 1'bz;
    assign dq_o = (!oe_n_i && !ce_n_i) ? q : ~q;
    // embedded algorithm; a stale token means a reset cut it short
    task automatic start(input [18:0] a, input [7:0] d, input [1:0] m);
        int k;
        begin
            pa = a;
            pv = d;
            busy = 1;
            tok++;
            k = tok;
            ers = (m != 0);
            all = (m == 2);
            es = a[18:13];
            lim = (m == 0) && mem.exists(a) && ((d & ~mem[a]) != 0);
            fork
                begin
                    #(((m == 0) && (a[18:13] == PROT_SEC)) ? 2000 : BUSY_NS);
                    if (k == tok && !lim) begin
                        foreach (mem[i]) begin
                            if (i[18:13] != PROT_SEC && (all || (ers && i[18:13] == es)))
                                mem[i] = 8'hff;
                        end
                        if (!ers && pa[18:13] != PROT_SEC) mem[pa] = pv;
                        busy = 0;
                    end
                end
            join_none
        end
    endtask
    // one command cycle; unlock addresses decoded on the low address bits only
    task automatic cyc(input [18:0] a, input [7:0] d);
        begin
            wcnt++;
            last_wd = d;
            if (d == `CMD_RESET) begin
                busy = 0;
                lim = 0;
                tok++;
                st = 0;
                asel = 0;
            end else if (busy) st = 0;
            else if (st == 7) begin
                byp = (d != `CMD_BYPASS_EXIT2);
                st = 0;
            end else if (st == 3) begin
                st = 0;
                start(a, d, 2'd0);
            end else if (st == 6) begin
                st = 0;
                if (d == `CMD_CHIP_ERASE) start(a, d, 2'd2);
                if (d == `CMD_SECTOR_ERASE) start(a, d, 2'd1);
            end else if (byp && st == 0 && d == `CMD_PROGRAM) st = 3;
            else if (byp && st == 0 && d == `CMD_BYPASS_EXIT1) st = 7;
            else if (d == `UNLOCK_DATA1 && a[10:0] == 11'h555 && (st == 0 || st == 4))
                st = st + 1;
            else if (d == `UNLOCK_DATA2 && a[10:0] == 11'h2aa && (st == 1 || st == 5))
                st = st + 1;
            else if (st == 2) begin
                st = (d == `CMD_PROGRAM) ? 3 : (d == `CMD_ERASE_SETUP) ? 4 : 0;
                asel = asel | (d == `CMD_AUTOSEL);
                byp = byp | (d == `CMD_BYPASS);
            end else st = 0;
        end
    endtask
    // address on the later falling edge, data on the earlier rising edge
    always @(negedge we_n_i or negedge ce_n_i) if (!we_n_i && !ce_n_i) la <= addr_i;
    always @(posedge we_n_i or posedge ce_n_i) if (we_n_i != ce_n_i) cyc(la, dq_i);
    // status or array byte launched at the start of each read
    always @(negedge oe_n_i) begin
        if (ce_n_i) q = ~q;
        else if (busy) begin
            ok = ers ? (all || addr_i[18:13] == es) : (addr_i == pa);
            q = {ok ? (ers ? 1'b0 : ~pv[7]) : t1, t1, lim, 1'b0, ers, t2, 2'b00};
            t1 = ~t1;
            if (ers && addr_i[18:13] == es) t2 = ~t2;
        end else if (asel)
            q = (addr_i[7:0] == 8'h02) ? {7'h0, addr_i[18:13] == PROT_SEC} : ID_MFR;
        else q = mem.exists(addr_i) ? mem[addr_i] : 8'hff;
    end
endmodule // flash_partner

// >>> testbench.sv
// self-checking bench for the flash status controller
`timescale 1ns/100ps
`include "flash_ctl_defines.vh"
module testbench;
    reg clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, pin_seen = 1'b0;
    reg [3:0] addr = 4'h0;
    reg [31:0] wdata = 32'h0, q;
    wire [31:0] rdata;
    wire [18:0] fa;
    wire ce_n, oe_n, we_n, dq_oe;
    wire [7:0] dq_w, dq_r;
    tri1 rb_n;
    int bad_count = 0, check_count = 0, w0;
    localparam [18:0] PA = 19'h10234, PB = 19'h20100, PP = 19'h7e010;
    // short poll limit keeps a stuck wait brief
    flash_status_ctl #(.MAX_POLLS(16'h0040)) flash_status_ctl_i (
        .CLOCK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .FL_ADDR_O(fa), .FL_CE_N_O(ce_n), .FL_OE_N_O(oe_n),
        .FL_WE_N_O(we_n), .FL_DQ_O(dq_w), .FL_DQ_OE_O(dq_oe), .FL_DQ_I(dq_r),
        .FL_READY_BUSY_N_I(rb_n));
    flash_partner flash_partner_i (.addr_i(fa), .ce_n_i(ce_n), .oe_n_i(oe_n),
        .we_n_i(we_n), .dq_i(dq_w), .dq_o(dq_r), .rb_n_o(rb_n));
    // ==========================================
    // clock and bus tasks
    initial begin
        forever #12.5 clk = ~clk;
    end
    task wr_reg(input [3:0] a, input [31:0] d);
        begin
            @(posedge clk);
            {addr, wdata, wr} <= {a, d, 1'b1};
            @(posedge clk);
            wr <= 1'b0;
        end
    endtask
    task rd_reg(input [3:0] a, output [31:0] o);
        begin
            @(posedge clk);
            {addr, rd} <= {a, 1'b1};
            @(posedge clk);
            rd <= 1'b0;
            @(negedge clk);
            o = rdata;
        end
    endtask
    task chk(input [31:0] g, input [31:0] e);
        begin
            check_count++;
            if (g !== e) begin
                $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
                bad_count++;
            end
        end
    endtask
    // command, then bounded wait on the busy flag
    task op(input [3:0] c);
        int n;
        begin
            wr_reg(`REG_CMD, {28'h0, c});
            n = 0;
            rd_reg(`REG_STATUS, q);
            while (q[0] !== 1'b0 && n < 4000) begin
                pin_seen = pin_seen | q[5];
                rd_reg(`REG_STATUS, q);
                n++;
            end
            if (n == 4000) bad_count++;
        end
    endtask
    task prog(input [18:0] a, input [7:0] d, input [3:0] c);
        begin
            wr_reg(`REG_ADDR, {13'h0, a});
            wr_reg(`REG_DATA, {24'h0, d});
            op(c);
        end
    endtask
    task arr(input [18:0] a);
        begin
            wr_reg(`REG_ADDR, {13'h0, a});
            op(`OP_READ);
            rd_reg(`REG_RDATA, q);
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", check_count, bad_count);
            if (bad_count == 0 && check_count > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    // ==========================================
    // watchdog
    initial begin
        #600000;
        bad_count++;
        stop_test;
    end
    // ==========================================
    // main sequence
    initial begin
        flash_partner_i.mem[PP] = 8'h77;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(`REG_STATUS, q);
        chk(q, 32'h0);
        wr_reg(`REG_ADDR, {13'h0, PA});
        wr_reg(4'hf, 32'h1);
        rd_reg(`REG_ADDR, q);
        chk(q, {13'h0, PA});
        prog(PA, 8'h5a, `OP_PROGRAM);
        chk(pin_seen, 1'b1);
        rd_reg(`REG_RDATA, q);
        chk(q[7:0], 8'h5a);
        rd_reg(`REG_STATUS, q);
        chk(q[2], 1'b0);
        w0 = flash_partner_i.wcnt;
        op(`OP_RESUME);
        rd_reg(`REG_STATUS, q);
        chk({q[2], flash_partner_i.wcnt == w0}, 2'b11);
        arr(PA);
        chk(q[7:0], 8'h5a);
        prog(PP, 8'h00, `OP_PROGRAM);
        arr(PP);
        chk(q[7:0], 8'h77);
        // protection query on a guarded and an open sector
        wr_reg(`REG_ADDR, {13'h0, 6'h3f, 13'h0002});
        op(`OP_AUTOSEL);
        rd_reg(`REG_RDATA, q);
        chk(q[7:0], 8'h01);
        wr_reg(`REG_ADDR, {13'h0, 6'h08, 13'h0002});
        op(`OP_AUTOSEL);
        rd_reg(`REG_RDATA, q);
        chk(q[7:0], 8'h00);
        op(`OP_RESET);
        arr(PA);
        chk(q[7:0], 8'h5a);
        // short program refused, then accepted inside bypass mode
        w0 = flash_partner_i.wcnt;
        prog(PB, 8'h3c, `OP_BYPASS_PROG);
        chk(flash_partner_i.wcnt == w0, 1'b1);
        op(`OP_BYPASS_ENTER);
        rd_reg(`REG_STATUS, q);
        chk(q[3], 1'b1);
        prog(PB, 8'h3c, `OP_BYPASS_PROG);
        op(`OP_BYPASS_EXIT);
        rd_reg(`REG_STATUS, q);
        chk({q[3], flash_partner_i.byp}, 2'b00);
        arr(PB);
        chk(q[7:0], 8'h3c);
        // a one over a zero runs out of time and must be reset
        prog(PA, 8'hff, `OP_PROGRAM);
        chk({flash_partner_i.busy, flash_partner_i.last_wd}, {1'b0, `CMD_RESET});
        arr(PA);
        chk(q[7:0], 8'h5a);
        wr_reg(`REG_ADDR, {13'h0, PA});
        op(`OP_SECTOR_ERASE);
        arr(PA);
        chk(q[7:0], 8'hff);
        arr(PB);
        chk(q[7:0], 8'h3c);
        op(`OP_CHIP_ERASE);
        arr(PB);
        chk(q[7:0], 8'hff);
        arr(PP);
        chk(q[7:0], 8'h77);
        // resume is accepted once a suspend has been issued
        op(`OP_SUSPEND);
        rd_reg(`REG_STATUS, q);
        chk(q[4:2], 3'b100);
        op(`OP_RESUME);
        rd_reg(`REG_STATUS, q);
        chk(q[4:2], 3'b000);
        stop_test;
    end
endmodule // testbench
